// >>> hdl/port_ctl_defs.svh
// What this block does
// - disabled unit still tests; abort keeps disable
// - enable or disable command ends test
// - control enable frees and restores tributaries
// - disabled modem neither originates nor answers
// - six independent per-port transmit enables
// - speed-disabled ports not selectable
// - mux modes monitor port or aggregate
// - monitor selection applies on save; undo restores
// - monitor selection local operation only
// - four general-purpose leads are readable
// - output leads writable only when allowed
// - lead changes reported in poll response
// - remote device command address picks target
`ifndef PORT_CTL_DEFS_SVH
`define PORT_CTL_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CMD      4'h0
`define REG_PORT_EN  4'h1
`define REG_MON_SEL  4'h2
`define REG_LEADS    4'h3
`define REG_CONFIG   4'h4
`define REG_STATUS   4'h5
`define REG_CHANGE   4'h6

// ----------------------------------------------------------------
// command codes in cmd register bits 3:0, target in bits 6:4
// ----------------------------------------------------------------
`define CMD_DSU_EN     4'h1
`define CMD_DSU_DIS    4'h2
`define CMD_MDM_EN     4'h3
`define CMD_MDM_DIS    4'h4
`define CMD_PORT_EN    4'h5
`define CMD_PORT_DIS   4'h6
`define CMD_DEV_EN     4'h7
`define CMD_DEV_DIS    4'h8
`define CMD_TEST_GO    4'h9
`define CMD_TEST_ABORT 4'ha
`define CMD_MON_SAVE   4'hb
`define CMD_MON_UNDO   4'hc
`define CMD_ARG_LSB    4
`define CMD_REMOTE_BIT 7
`define CMD_SRC_BIT    8

// ----------------------------------------------------------------
// config field positions and reset values
// ----------------------------------------------------------------
`define CFG_MODE_LSB   0
`define CFG_WRITABLE   2
`define CFG_PROTO_A    3
`define CFG_NOTIFY     4
`define CFG_CONTROL    5
`define CFG_DEV_ADDR   8
`define CFG_SPEED_LSB  16
`define RST_CONFIG     32'h00000000
`define RST_PORT_EN    6'h3f
`define MON_AGGR       3'h7

`endif

// >>> hdl/port_ctl_pkg.sv
package port_ctl_pkg;
    // operating mode from config bits 1:0
    typedef enum logic [1:0] {
        MODE_BASIC  = 2'h0,
        MODE_MUX    = 2'h1,
        MODE_MULTI  = 2'h2,
        MODE_BRIDGE = 2'h3
    } op_mode_e;
    // test progress, one-hot
    typedef enum logic [1:0] {
        TEST_IDLE = 2'b01,
        TEST_RUN  = 2'b10
    } test_state_e;
endpackage

// >>> hdl/port_ctl_monitor.sv
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "port_ctl_defs.svh"

module port_ctl_monitor #(
    parameter int NPORTS = 6
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [3:0]        addr_in,
    input  wire logic [31:0]       wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [31:0]       rdata_out,
    input  wire logic [NPORTS-1:0] port_activity_in,
    input  wire logic              aggr_activity_in,
    input  wire logic [1:0]        alarm_leads_in,
    input  wire logic              poll_in,
    output logic      [1:0]        control_leads_out,
    output logic                   unit_tx_en_out,
    output logic                   modem_en_out,
    output logic      [NPORTS-1:0] port_tx_en_out,
    output logic                   test_active_out,
    output logic                   status_led_out,
    output logic      [2:0]        mon_sel_out,
    output logic                   poll_change_out,
    output logic      [3:0]        poll_leads_out
);

    // ----------------------------------------------------------------
    // input synchronisers for pins
    // ----------------------------------------------------------------
    logic [NPORTS:0] act_s1;     // first stage, read only by stage two
    logic [NPORTS:0] act_s2;     // usable activity
    logic [1:0]      alm_s1;     // first stage alarm leads
    logic [1:0]      alm_s2;     // usable alarm leads

    // two flops before any logic looks at an activity or alarm pin
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            act_s1 <= '0;
            act_s2 <= '0;
            alm_s1 <= 2'h0;
            alm_s2 <= 2'h0;
        end else begin
            act_s1 <= {aggr_activity_in, port_activity_in};
            act_s2 <= act_s1;
            alm_s1 <= alarm_leads_in;
            alm_s2 <= alm_s1;
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic        cmd_wr;         // write to command register
    logic [3:0]  cmd_code;       // command opcode
    logic [2:0]  cmd_arg;        // port number or device address
    logic        cmd_remote;     // command arrives addressed remotely
    logic        cmd_from_nms;   // source is management system
    port_ctl_pkg::op_mode_e mode;
    logic [31:0] config_q;       // configuration register
    logic [31:0] next_config;
    logic [NPORTS-1:0] speed_ok; // port speed option not disabled
    logic        mux_mode;       // multiplexer or multipoint

    assign cmd_wr       = wr_in && (addr_in == `REG_CMD);
    assign cmd_code     = wdata_in[3:0];
    assign cmd_arg      = wdata_in[`CMD_ARG_LSB +: 3];
    assign cmd_remote   = wdata_in[`CMD_REMOTE_BIT];
    assign cmd_from_nms = wdata_in[`CMD_SRC_BIT];
    assign mode         = port_ctl_pkg::op_mode_e'(config_q[`CFG_MODE_LSB +: 2]);
    assign speed_ok     = config_q[`CFG_SPEED_LSB +: NPORTS];
    assign mux_mode     = (mode == port_ctl_pkg::MODE_MUX) || (mode == port_ctl_pkg::MODE_MULTI);

    // port number 1..6 to one-hot mask, zero when out of range
    function automatic logic [NPORTS-1:0] port_mask(input logic [2:0] num);
        logic [NPORTS-1:0] m;
        m = '0;
        for (int i = 0; i < NPORTS; i++) begin
            if (num == 3'(i + 1)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // ----------------------------------------------------------------
    // transmit enables and test state
    // ----------------------------------------------------------------
    logic              unit_en;
    logic              next_unit_en;
    logic              modem_en;
    logic              next_modem_en;
    logic [NPORTS-1:0] port_en;
    logic [NPORTS-1:0] next_port_en;
    port_ctl_pkg::test_state_e test_st;
    port_ctl_pkg::test_state_e next_test_st;
    logic [NPORTS-1:0] sel_mask;     // addressed port, if selectable
    logic              dev_modem;    // remote device address hits modem

    assign sel_mask  = port_mask(cmd_arg) & speed_ok;
    assign dev_modem = (cmd_arg == config_q[`CFG_DEV_ADDR +: 3]);

    // next state for enables; untouched values simply hold
    always_comb begin
        next_unit_en  = unit_en;
        next_modem_en = modem_en;
        next_port_en  = port_en;
        next_test_st  = test_st;
        if (cmd_wr) begin
            case (cmd_code)
                `CMD_DSU_EN: begin
                    next_unit_en = 1'b1;
                    next_test_st = port_ctl_pkg::TEST_IDLE;
                    if (config_q[`CFG_CONTROL]) begin
                        next_port_en = next_port_en | speed_ok;
                    end
                end
                `CMD_DSU_DIS: begin
                    next_unit_en = 1'b0;
                    next_test_st = port_ctl_pkg::TEST_IDLE;
                end
                // modem calls held off until enabled
                `CMD_MDM_EN:  next_modem_en = 1'b1;
                `CMD_MDM_DIS: next_modem_en = 1'b0;
                // independent port enables, gated by speed option
                `CMD_PORT_EN: begin
                    if (mux_mode) begin
                        next_port_en = port_en | sel_mask;
                    end
                end
                `CMD_PORT_DIS: begin
                    if (mux_mode) begin
                        next_port_en = port_en & ~sel_mask;
                    end
                end
                // address picks unit or modem, remote modem disable
                `CMD_DEV_EN: begin
                    if (dev_modem) begin
                        next_modem_en = 1'b1;
                    end else begin
                        next_unit_en = 1'b1;
                        next_test_st = port_ctl_pkg::TEST_IDLE;
                    end
                end
                `CMD_DEV_DIS: begin
                    if (dev_modem) begin
                        next_modem_en = 1'b0;
                    end else begin
                        next_unit_en = 1'b0;
                        next_test_st = port_ctl_pkg::TEST_IDLE;
                    end
                end
                `CMD_TEST_GO:    next_test_st = port_ctl_pkg::TEST_RUN;
                `CMD_TEST_ABORT: next_test_st = port_ctl_pkg::TEST_IDLE;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_en  <= 1'b1;
            modem_en <= 1'b1;
            port_en  <= `RST_PORT_EN;
            test_st  <= port_ctl_pkg::TEST_IDLE;
        end else begin
            unit_en  <= next_unit_en;
            modem_en <= next_modem_en;
            port_en  <= next_port_en;
            test_st  <= next_test_st;
        end
    end

    // ----------------------------------------------------------------
    // monitor selection with load, save and undo
    // ----------------------------------------------------------------
    logic [2:0] mon_active;      // applied selection
    logic [2:0] next_mon_active;
    logic [2:0] mon_pending;     // loaded but unsaved selection
    logic [2:0] next_mon_pending;
    logic       mon_valid;       // pending value is a legal source

    // 1..6 or the aggregate/bridge path code; zero is rejected
    assign mon_valid = (mon_pending == `MON_AGGR) ||
                       ((mon_pending != 3'h0) && (mon_pending <= 3'(NPORTS)));

    always_comb begin
        next_mon_active  = mon_active;
        next_mon_pending = mon_pending;
        // local only, only with card modes
        if (wr_in && addr_in == `REG_MON_SEL && !wdata_in[`CMD_REMOTE_BIT]
            && mode != port_ctl_pkg::MODE_BASIC) begin
            next_mon_pending = wdata_in[2:0];
        end
        if (cmd_wr && !cmd_remote) begin
            if (cmd_code == `CMD_MON_SAVE && mon_valid) begin
                next_mon_active = mon_pending;
            end
            if (cmd_code == `CMD_MON_UNDO) begin
                next_mon_pending = mon_active;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mon_active  <= `MON_AGGR;
            mon_pending <= `MON_AGGR;
        end else begin
            mon_active  <= next_mon_active;
            mon_pending <= next_mon_pending;
        end
    end

    // ----------------------------------------------------------------
    // external leads and change notification
    // ----------------------------------------------------------------
    logic [1:0] ctl_leads;
    logic [1:0] next_ctl_leads;
    logic [3:0] leads_prev;      // last sampled lead set
    logic [3:0] lead_chg;        // sticky change bits
    logic [3:0] next_lead_chg;
    logic [3:0] leads_now;
    logic       notify_on;

    assign leads_now = {alm_s2, ctl_leads};
    assign notify_on = config_q[`CFG_PROTO_A] && config_q[`CFG_NOTIFY] && config_q[`CFG_CONTROL];

    always_comb begin
        next_ctl_leads = ctl_leads;
        // writable only with the option set
        if (wr_in && addr_in == `REG_LEADS && config_q[`CFG_WRITABLE]) begin
            next_ctl_leads = wdata_in[1:0];
        end
        // poll report clears; a change in the same cycle wins
        next_lead_chg = poll_in ? 4'h0 : lead_chg;
        if (notify_on) begin
            next_lead_chg = next_lead_chg | (leads_now ^ leads_prev);
        end
        next_config = config_q;
        if (wr_in && addr_in == `REG_CONFIG) begin
            next_config = wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_leads  <= 2'h0;
            leads_prev <= 4'h0;
            lead_chg   <= 4'h0;
            config_q   <= `RST_CONFIG;
        end else begin
            ctl_leads  <= next_ctl_leads;
            leads_prev <= leads_now;
            lead_chg   <= next_lead_chg;
            config_q   <= next_config;
        end
    end

    // ----------------------------------------------------------------
    // outputs and read port
    // ----------------------------------------------------------------
    logic        led_q;
    logic        poll_chg_q;
    logic [3:0]  poll_leads_q;
    logic [31:0] rdata_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            led_q        <= 1'b0;
            poll_chg_q   <= 1'b0;
            poll_leads_q <= 4'h0;
            rdata_q      <= 32'h0;
        end else begin
            // route selected activity; aggregate code uses last input
            led_q        <= (mon_active == `MON_AGGR) ? act_s2[NPORTS]
                          : ((act_s2[NPORTS-1:0] & port_mask(mon_active)) != '0);
            poll_chg_q   <= poll_in && notify_on && (lead_chg != 4'h0);
            poll_leads_q <= poll_in ? leads_now : poll_leads_q;
            rdata_q      <= 32'h0;
            if (rd_in) begin
                case (addr_in)
                    `REG_PORT_EN: rdata_q <= 32'(port_en);
                    `REG_MON_SEL: rdata_q <= {26'h0, mon_pending, mon_active};
                    `REG_LEADS:   rdata_q <= {28'h0, leads_now};
                    `REG_CONFIG:  rdata_q <= config_q;
                    `REG_STATUS:  rdata_q <= {29'h0, test_st == port_ctl_pkg::TEST_RUN,
                                              modem_en, unit_en};
                    `REG_CHANGE:  rdata_q <= {28'h0, lead_chg};
                    default:      rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign rdata_out         = rdata_q;
    assign control_leads_out = ctl_leads;
    assign unit_tx_en_out    = unit_en;
    assign modem_en_out      = modem_en;
    assign port_tx_en_out    = port_en;
    assign test_active_out   = (test_st == port_ctl_pkg::TEST_RUN);
    assign status_led_out    = led_q;
    assign mon_sel_out       = mon_active;
    assign poll_change_out   = poll_chg_q;
    assign poll_leads_out    = poll_leads_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_ABORT_KEEPS_DIS: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && cmd_code == `CMD_TEST_ABORT && !unit_en) |=> (!unit_en && !test_active_out))
        else $error("abort changed transmitter state");
    AST_CMD_ENDS_TEST: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && (cmd_code == `CMD_DSU_EN || cmd_code == `CMD_DSU_DIS)) |=> !test_active_out)
        else $error("test survived enable or disable");
    AST_CTRL_RESTORE: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && cmd_code == `CMD_DSU_EN && config_q[`CFG_CONTROL]) |=>
        ((port_tx_en_out & $past(speed_ok)) == $past(speed_ok)))
        else $error("tributaries not restored");
    AST_MODEM_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
        (!modem_en && !(cmd_wr && (cmd_code == `CMD_MDM_EN || cmd_code == `CMD_DEV_EN)))
        |=> !modem_en_out)
        else $error("modem enabled without command");
    AST_SPEED_GATE: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && cmd_code == `CMD_PORT_EN && (port_mask(cmd_arg) & ~speed_ok) != '0
         && !port_en[cmd_arg - 3'h1]) |=> !port_tx_en_out[$past(cmd_arg) - 3'h1])
        else $error("speed-disabled port enabled");
    AST_SAVE_ONLY: assert property (@(posedge clk_in) disable iff (rst_in)
        !(cmd_wr && cmd_code == `CMD_MON_SAVE) |=> $stable(mon_sel_out))
        else $error("monitor changed without save");
    AST_LEADS_LOCK: assert property (@(posedge clk_in) disable iff (rst_in)
        !config_q[`CFG_WRITABLE] |=> $stable(control_leads_out))
        else $error("output leads changed while locked");
    AST_NOTIFY: assert property (@(posedge clk_in) disable iff (rst_in)
        (poll_in && notify_on && lead_chg != 4'h0) |=> poll_change_out)
        else $error("lead change not reported");

endmodule
`default_nettype wire

// >>> sim/panel_host.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// operator panel / management host, register bus master
// ------------------------------------------------------------
module panel_host (
    input  wire logic        clk_in,
    input  wire logic [31:0] rdata_in,
    output logic      [3:0]  addr_out,
    output logic      [31:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out
);
    // bus idle from time zero so no strobe starts unknown
    initial begin
        addr_out  = 4'h0;
        wdata_out = 32'h00000000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // one-cycle write; gap lets the host answer slowly
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input int gap);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        // released data must not keep showing the last value
        wdata_out <= ~d;
    endtask

    // one-cycle read; data stand only in the following cycle
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        // data launched at this edge stand until the next one
        #1 d = rdata_in;
    endtask
endmodule

`default_nettype wire

// >>> sim/dsu_port_control_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dsu_port_control_monitor_tb;
    // ------------------------------------------------------------
    // signals and bench model state
    // ------------------------------------------------------------
    logic        clk = 1'b0;              // 250 MHz
    logic        rst = 1'b1;              // async, active high
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, rd_v;
    logic        wr, rd, led, pchg, uen, men, tst;
    logic        aggr = 1'b0, poll = 1'b0;
    logic [5:0]  pact = 6'h00, pen;
    logic [1:0]  alm = 2'h0, ctl;
    logic [2:0]  msel;
    logic [3:0]  pleads;
    logic [7:0]  rnd = 8'h5c;            // lfsr state, seed 92
    int          errors = 0, compares = 0, cycles = 0;
    int          m_unit, m_modem, m_test, m_mon, m_pend;
    logic [5:0]  m_ports;
    logic [31:0] m_cfg;
    logic [1:0]  m_ctl, m_alm;

    always #2 clk = ~clk;

    panel_host host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
                     .wr_out(wr), .rd_out(rd));

    port_ctl_monitor #(.NPORTS(6)) DUT (
        .clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .port_activity_in(pact), .aggr_activity_in(aggr),
        .alarm_leads_in(alm), .poll_in(poll), .control_leads_out(ctl),
        .unit_tx_en_out(uen), .modem_en_out(men), .port_tx_en_out(pen),
        .test_active_out(tst), .status_led_out(led), .mon_sel_out(msel),
        .poll_change_out(pchg), .poll_leads_out(pleads));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic stop_test();
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // all state outputs against the model in one word
    task automatic cmp_out();
        logic [13:0] g, e;
        g = {ctl, msel, tst, men, uen, pen};
        e = {m_ctl, m_mon[2:0], m_test[0], m_modem[0], m_unit[0], m_ports};
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // command decode as the bench understands it; refused ones change nothing
    task automatic model_cmd(input logic [3:0] op, input logic [2:0] arg, input logic rem);
        logic [5:0] sp;
        sp = m_cfg[21:16];
        case (op)
            4'h1: begin
                m_unit = 1;
                m_test = 0;
                if (m_cfg[5]) m_ports = m_ports | sp;
            end
            4'h2: begin
                m_unit = 0;
                m_test = 0;
            end
            4'h3: m_modem = 1;
            4'h4: m_modem = 0;
            4'h5, 4'h6: begin
                if ((m_cfg[1:0] == 2'h1 || m_cfg[1:0] == 2'h2) && arg != 3'h0 && arg != 3'h7
                    && sp[arg - 3'h1]) m_ports[arg - 3'h1] = (op == 4'h5);
            end
            4'h7, 4'h8: begin
                if (arg == m_cfg[10:8]) m_modem = (op == 4'h7);
                else begin
                    // a unit enable or disable also ends any test
                    m_unit = (op == 4'h7);
                    m_test = 0;
                end
            end
            4'h9: m_test = 1;
            4'ha: m_test = 0;
            4'hb: if (!rem && m_pend != 0) m_mon = m_pend;
            4'hc: if (!rem) m_pend = m_mon;
            default: ;
        endcase
    endtask

    // write through the host with random pacing, then compare the state outputs
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        host.wr_reg(a, d, int'(rnd[0]));
        rnd = lfsr(rnd);
        case (a)
            4'h0: model_cmd(d[3:0], d[6:4], d[7]);
            4'h2: if (!d[7] && m_cfg[1:0] != 2'h0) m_pend = int'(d[2:0]);
            4'h3: if (m_cfg[2]) m_ctl = d[1:0];
            4'h4: m_cfg = d;
            default: ;
        endcase
        #1 cmp_out();
    endtask

    task automatic cmd(input logic [3:0] op, input logic [2:0] arg, input logic rem);
        wr_reg(4'h0, {24'h000000, rem, arg, op});
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        host.rd_reg(a, rd_v);
        cmp_val(rd_v, exp);
    endtask

    // poll pulse; report and snapshot show the cycle after it
    task automatic poll_chk(input logic exp);
        repeat (4) @(posedge clk);
        poll <= 1'b1;
        @(posedge clk);
        poll <= 1'b0;
        #1 cmp_val(32'({pchg, pleads}), 32'({exp, m_alm, m_ctl}));
    endtask

    // hang guard, about fifty times the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        m_unit = 1;
        m_modem = 1;
        m_test = 0;
        m_mon = 7;
        m_pend = 7;
        m_ports = 6'h3f;
        m_cfg = 32'h00000000;
        m_ctl = 2'h0;
        m_alm = 2'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1 cmp_out();
        rd_chk(4'h4, 32'h00000000);
        rd_chk(4'h1, 32'h0000003f);
        rd_chk(4'h5, 32'h00000003);
        rd_chk(4'hf, 32'h00000000);
        cmd(4'h2, 3'h0, 1'b0);
        cmd(4'h9, 3'h0, 1'b0);
        cmd(4'ha, 3'h0, 1'b0);
        rd_chk(4'h5, 32'h00000002);
        cmd(4'h9, 3'h0, 1'b0);
        cmd(4'h1, 3'h0, 1'b0);
        cmd(4'h9, 3'h0, 1'b0);
        cmd(4'h2, 3'h0, 1'b0);
        cmd(4'h1, 3'h0, 1'b0);
        cmd(4'h4, 3'h0, 1'b0);
        cmd(4'h3, 3'h0, 1'b0);
        // mux mode, port 3 speed off, modem at address 5
        wr_reg(4'h4, 32'h003b0501);
        for (int i = 0; i < 8; i++) cmd(4'h6, 3'(i), 1'b0);
        rd_chk(4'h1, 32'h00000004);
        for (int i = 1; i < 7; i++) cmd(4'h5, 3'(i), 1'b0);
        wr_reg(4'h4, 32'h003f0501);
        cmd(4'h6, 3'h3, 1'b0);
        wr_reg(4'h4, 32'h003b0501);
        cmd(4'h5, 3'h3, 1'b0);
        cmd(4'h6, 3'h2, 1'b0);
        cmd(4'h6, 3'h5, 1'b0);
        wr_reg(4'h4, 32'h003b0521);
        cmd(4'h9, 3'h0, 1'b0);
        cmd(4'h1, 3'h0, 1'b0);
        cmd(4'h8, 3'h5, 1'b1);
        cmd(4'h7, 3'h5, 1'b1);
        cmd(4'h9, 3'h0, 1'b0);
        cmd(4'h8, 3'h2, 1'b1);
        cmd(4'h7, 3'h2, 1'b1);
        wr_reg(4'h2, 32'h00000003);
        rd_chk(4'h2, 32'({m_pend[2:0], m_mon[2:0]}));
        cmd(4'hb, 3'h0, 1'b0);
        wr_reg(4'h2, 32'h00000005);
        cmd(4'hc, 3'h0, 1'b0);
        rd_chk(4'h2, 32'({m_pend[2:0], m_mon[2:0]}));
        wr_reg(4'h2, 32'h00000086);
        wr_reg(4'h2, 32'h00000006);
        cmd(4'hb, 3'h0, 1'b1);
        wr_reg(4'h2, 32'h00000000);
        cmd(4'hb, 3'h0, 1'b0);
        // every monitor source with random activity held steady
        for (int s = 1; s < 8; s++) begin
            wr_reg(4'h2, 32'(s));
            cmd(4'hb, 3'h0, 1'b0);
            repeat (3) begin
                @(posedge clk);
                pact <= rnd[5:0];
                aggr <= rnd[6];
                rnd = lfsr(rnd);
                repeat (5) @(posedge clk);
                #1 cmp_val(32'(led), 32'(s == 7 ? aggr : pact[s - 1]));
            end
        end
        wr_reg(4'h4, 32'h003b0523);
        cmd(4'h6, 3'h2, 1'b0);
        wr_reg(4'h2, 32'h00000001);
        cmd(4'hb, 3'h0, 1'b0);
        wr_reg(4'h2, 32'h00000007);
        cmd(4'hb, 3'h0, 1'b0);
        wr_reg(4'h4, 32'h003b0520);
        wr_reg(4'h2, 32'h00000004);
        cmd(4'hb, 3'h0, 1'b0);
        wr_reg(4'h3, 32'h00000003);
        @(posedge clk);
        alm <= rnd[1:0] | 2'h1;
        m_alm = rnd[1:0] | 2'h1;
        repeat (4) @(posedge clk);
        rd_chk(4'h3, 32'({m_alm, m_ctl}));
        wr_reg(4'h4, 32'h003b053c);
        wr_reg(4'h3, 32'h00000002);
        rd_chk(4'h3, 32'({m_alm, m_ctl}));
        rd_chk(4'h6, 32'h00000002);
        poll_chk(1'b1);
        poll_chk(1'b0);
        wr_reg(4'h3, 32'h00000001);
        poll_chk(1'b1);
        wr_reg(4'h4, 32'h003b052c);
        wr_reg(4'h3, 32'h00000002);
        poll_chk(1'b0);
        rd_chk(4'h1, 32'(m_ports));
        rd_chk(4'h5, 32'({m_test[0], m_modem[0], m_unit[0]}));
        stop_test();
    end
endmodule

`default_nettype wire
